// ---- eic_pkg.sv ----
// constants and types for the extended interrupt control bits block
package eic_pkg;

  // ***********************************************
  // register map
  // ***********************************************
  localparam int unsigned EIC_AW       = 12;
  localparam logic [11:0] EIC_CTRL_OFS = 12'h000; // extended_interrupt_control
  localparam logic [11:0] EIC_AUX_OFS  = 12'h004; // auxiliary control and state

  // ***********************************************
  // field positions, extended_interrupt_control
  // ***********************************************
  localparam int unsigned EIC_LTX_IE_BIT    = 14;
  localparam int unsigned EIC_SYS_FLAG_BIT  = 11;
  localparam int unsigned EIC_SYS_IE_BIT    = 10;
  localparam int unsigned EIC_EXD_FLAG_BIT  = 7;
  localparam int unsigned EIC_EXD_IE_BIT    = 6;
  localparam int unsigned EIC_ANY_DEST_BIT  = 5;
  localparam int unsigned EIC_WAKE_FLAG_BIT = 4;
  localparam int unsigned EIC_WAKE_IE_BIT   = 3;
  localparam int unsigned EIC_HOST_WAKE_BIT = 2;
  localparam int unsigned EIC_WAKE_MODE_BIT = 1;

  // ***********************************************
  // field positions, auxiliary register
  // ***********************************************
  localparam int unsigned EIC_GIE_BIT      = 0;
  localparam int unsigned EIC_EXT_ANY_BIT  = 1;
  localparam int unsigned EIC_STOP_BIT     = 2;
  localparam int unsigned EIC_SRST_BIT     = 3;
  localparam int unsigned EIC_MODE_ST_BIT  = 4;
  localparam int unsigned EIC_INT_ST_BIT   = 5;

  // ***********************************************
  // reset values and counts
  // ***********************************************
  localparam logic        EIC_BIT_RST    = 1'b0;
  localparam logic [31:0] EIC_RD_RST     = 32'h0000_0000;
  localparam logic [2:0]  EIC_ADDR_LAST  = 3'h5;  // last byte index of station address
  localparam logic [4:0]  EIC_MAGIC_REPS = 5'h10; // consecutive address copies needed

  // frame walker states
  typedef enum logic [1:0]
  {
    EIC_ST_IDLE = 2'b00,
    EIC_ST_DEST = 2'b01,
    EIC_ST_BODY = 2'b10
  } eic_rx_state_t;

endpackage

// ---- eic_top.sv ----
// extended interrupt control bits with apb slave and wake frame detector
//
// Contract
// - last-tx enable cleared by hard/soft reset, kept on stop, always read/write.
// - reserved positions written zero by software; they read back as zero here.
// - system-error flag set on bus-master parity error, master or target abort.
// - parity error sets system-error flag whatever the parity response setting.
// - system-error flag with its enable drives interrupt without global enable.
// - system-error flag write-one clears, hard/soft reset clear, stop keeps.
// - clearing pci status bits leaves system-error flag untouched.
// - system-error enable gates combined flag; hard/soft reset clear, stop keeps.
// - excessive-deferral flag set when transmitter suffers excessive deferral.
// - excessive-deferral flag with its enable drives the interrupt.
// - excessive-deferral flag write-one clears; only hard reset clears otherwise.
// - excessive-deferral enable gates combined flag; only hard reset clears it.
// - any-destination bit zero needs station address destination, one accepts all.
// - wake frame needs sixteen consecutive copies of the station address.
// - effective any-destination accept is this bit OR the extended bit.
// - any-destination bit cleared by hard/soft reset, kept on stop.
// - wake flag set on valid wake frame while in wake-frame mode.
// - wake flag interrupts only with global enable and wake enable both set.
// - wake flag write-one clears; hard reset, soft reset and stop clear it.
// - wake enable gates combined flag; hard/soft reset clear, stop keeps.
// - wake-frame mode is wake-mode bit and (power good or host wake enable).
`timescale 1ns/1ps
`default_nettype none

module eic_top
  import eic_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [eic_pkg::EIC_AW-1:0] paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  input  wire logic                   bm_parity_err_i,
  input  wire logic                   bm_master_abort_i,
  input  wire logic                   bm_target_abort_i,
  input  wire logic                   tx_excess_defer_i,
  input  wire logic                   rx_valid_i,
  input  wire logic                   rx_sof_i,
  input  wire logic                   rx_eof_i,
  input  wire logic [7:0]             rx_data_i,
  input  wire logic [47:0]            station_address_i,
  input  wire logic                   power_good_input_i,
  output logic                        pci_int_o,
  output logic                        combined_int_flag_o,
  output logic                        wake_mode_o,
  output logic                        last_tx_int_enable_o
);

  // ***********************************************
  // helpers
  // ***********************************************

  // byte i of the station address, byte 0 is bits 47:40
  function automatic logic [7:0] eic_addr_byte(input logic [47:0] a, input logic [2:0] i);
    logic [47:0] s;
    s = a << {i, 3'b000};
    return s[47:40];
  endfunction

  // ***********************************************
  // declarations
  // ***********************************************
  logic        pready_q, pready_d;
  logic        pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic        ltx_ie_q, ltx_ie_d;
  logic        sys_flag_q, sys_flag_d;
  logic        sys_ie_q, sys_ie_d;
  logic        exd_flag_q, exd_flag_d;
  logic        exd_ie_q, exd_ie_d;
  logic        any_dest_q, any_dest_d;
  logic        wake_flag_q, wake_flag_d;
  logic        wake_ie_q, wake_ie_d;
  logic        host_wake_q, host_wake_d;
  logic        wake_bit_q, wake_bit_d;
  logic        gie_q, gie_d;
  logic        ext_any_q, ext_any_d;
  logic        pci_int_q, pci_int_d;
  logic        comb_int_q, comb_int_d;
  logic        mode_q, mode_d;
  logic        pg_s1_q, pg_s2_q, pg_s3_q;
  logic        pg_q, pg_d;
  eic_rx_state_t st_q, st_d;
  logic [2:0]  idx_q, idx_d;
  logic [4:0]  reps_q, reps_d;
  logic        dest_ok_q, dest_ok_d;
  logic        found_q, found_d;
  logic        access, wr_done, wr_ctrl, wr_aux;
  logic        soft_rst, stop_set;
  logic        sys_set, wake_hit;
  logic        any_dest_eff;
  logic [31:0] ctrl_rd, aux_rd;

  // ***********************************************
  // apb slave
  // ***********************************************

  // request decode, write lands when pready is seen high
  assign access  = psel_i & penable_i;
  assign wr_done = access & pready_q & pwrite_i;
  assign wr_ctrl = wr_done & (paddr_i == EIC_CTRL_OFS);
  assign wr_aux  = wr_done & (paddr_i == EIC_AUX_OFS);

  // one-cycle command strobes from the auxiliary register
  assign soft_rst = wr_aux & pwdata_i[EIC_SRST_BIT];
  assign stop_set = wr_aux & pwdata_i[EIC_STOP_BIT];

  // read images, unused positions read as zero
  always_comb
  begin
    ctrl_rd                    = EIC_RD_RST;
    ctrl_rd[EIC_LTX_IE_BIT]    = ltx_ie_q;
    ctrl_rd[EIC_SYS_FLAG_BIT]  = sys_flag_q;
    ctrl_rd[EIC_SYS_IE_BIT]    = sys_ie_q;
    ctrl_rd[EIC_EXD_FLAG_BIT]  = exd_flag_q;
    ctrl_rd[EIC_EXD_IE_BIT]    = exd_ie_q;
    ctrl_rd[EIC_ANY_DEST_BIT]  = any_dest_q;
    ctrl_rd[EIC_WAKE_FLAG_BIT] = wake_flag_q;
    ctrl_rd[EIC_WAKE_IE_BIT]   = wake_ie_q;
    ctrl_rd[EIC_HOST_WAKE_BIT] = host_wake_q;
    ctrl_rd[EIC_WAKE_MODE_BIT] = wake_bit_q;
    aux_rd                     = EIC_RD_RST;
    aux_rd[EIC_GIE_BIT]        = gie_q;
    aux_rd[EIC_EXT_ANY_BIT]    = ext_any_q;
    aux_rd[EIC_MODE_ST_BIT]    = mode_q;
    aux_rd[EIC_INT_ST_BIT]     = comb_int_q;
  end

  // answer one cycle into the access phase
  always_comb
  begin
    pready_d  = access & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (access & ~pready_q)
    begin
      if (paddr_i == EIC_CTRL_OFS)
      begin
        prdata_d = ctrl_rd;
      end
      else if (paddr_i == EIC_AUX_OFS)
      begin
        prdata_d = aux_rd;
      end
      else
      begin
        prdata_d  = EIC_RD_RST;
        pslverr_d = 1'b1; // unmapped address
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= EIC_RD_RST;
    end
    else
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ***********************************************
  // control and flag bits
  // ***********************************************

  // any one bus-master error sets the flag; parity response not consulted
  assign sys_set = bm_parity_err_i | bm_master_abort_i | bm_target_abort_i;

  always_comb
  begin
    ltx_ie_d    = ltx_ie_q;
    sys_ie_d    = sys_ie_q;
    exd_ie_d    = exd_ie_q;
    any_dest_d  = any_dest_q;
    wake_ie_d   = wake_ie_q;
    host_wake_d = host_wake_q;
    wake_bit_d  = wake_bit_q;
    gie_d       = gie_q;
    ext_any_d   = ext_any_q;
    // plain read/write fields
    if (wr_ctrl)
    begin
      ltx_ie_d    = pwdata_i[EIC_LTX_IE_BIT];
      sys_ie_d    = pwdata_i[EIC_SYS_IE_BIT];
      exd_ie_d    = pwdata_i[EIC_EXD_IE_BIT];
      any_dest_d  = pwdata_i[EIC_ANY_DEST_BIT];
      wake_ie_d   = pwdata_i[EIC_WAKE_IE_BIT];
      host_wake_d = pwdata_i[EIC_HOST_WAKE_BIT];
      wake_bit_d  = pwdata_i[EIC_WAKE_MODE_BIT];
    end
    if (wr_aux)
    begin
      gie_d     = pwdata_i[EIC_GIE_BIT];
      ext_any_d = pwdata_i[EIC_EXT_ANY_BIT];
    end
    // write-one clear, hardware set wins
    sys_flag_d  = sys_set | (sys_flag_q & ~(wr_ctrl & pwdata_i[EIC_SYS_FLAG_BIT]));
    exd_flag_d  = tx_excess_defer_i | (exd_flag_q & ~(wr_ctrl & pwdata_i[EIC_EXD_FLAG_BIT]));
    wake_flag_d = wake_hit | (wake_flag_q & ~(wr_ctrl & pwdata_i[EIC_WAKE_FLAG_BIT]));
    // stop clears only the wake flag and the global enable
    if (stop_set)
    begin
      wake_flag_d = 1'b0;
      gie_d       = 1'b0;
    end
    // soft reset; excessive-deferral pair is left alone
    if (soft_rst)
    begin
      ltx_ie_d    = EIC_BIT_RST;
      sys_flag_d  = EIC_BIT_RST;
      sys_ie_d    = EIC_BIT_RST;
      any_dest_d  = EIC_BIT_RST;
      wake_flag_d = EIC_BIT_RST;
      wake_ie_d   = EIC_BIT_RST;
      host_wake_d = EIC_BIT_RST;
      wake_bit_d  = EIC_BIT_RST;
      gie_d       = EIC_BIT_RST;
      ext_any_d   = EIC_BIT_RST;
    end
  end

  // hard reset clears every bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ltx_ie_q    <= EIC_BIT_RST;
      sys_flag_q  <= EIC_BIT_RST;
      sys_ie_q    <= EIC_BIT_RST;
      exd_flag_q  <= EIC_BIT_RST;
      exd_ie_q    <= EIC_BIT_RST;
      any_dest_q  <= EIC_BIT_RST;
      wake_flag_q <= EIC_BIT_RST;
      wake_ie_q   <= EIC_BIT_RST;
      host_wake_q <= EIC_BIT_RST;
      wake_bit_q  <= EIC_BIT_RST;
      gie_q       <= EIC_BIT_RST;
      ext_any_q   <= EIC_BIT_RST;
    end
    else
    begin
      ltx_ie_q    <= ltx_ie_d;
      sys_flag_q  <= sys_flag_d;
      sys_ie_q    <= sys_ie_d;
      exd_flag_q  <= exd_flag_d;
      exd_ie_q    <= exd_ie_d;
      any_dest_q  <= any_dest_d;
      wake_flag_q <= wake_flag_d;
      wake_ie_q   <= wake_ie_d;
      host_wake_q <= host_wake_d;
      wake_bit_q  <= wake_bit_d;
      gie_q       <= gie_d;
      ext_any_q   <= ext_any_d;
    end
  end

  // ***********************************************
  // power good synchroniser and wake mode
  // ***********************************************

  // change accepted once second and third stages agree
  assign pg_d = (pg_s2_q == pg_s3_q) ? pg_s3_q : pg_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pg_s1_q <= 1'b0;
      pg_s2_q <= 1'b0;
      pg_s3_q <= 1'b0;
      pg_q    <= 1'b0;
    end
    else
    begin
      pg_s1_q <= power_good_input_i;
      pg_s2_q <= pg_s1_q;
      pg_s3_q <= pg_s2_q;
      pg_q    <= pg_d;
    end
  end

  assign mode_d       = wake_bit_q & (pg_q | host_wake_q);
  assign any_dest_eff = any_dest_q | ext_any_q;

  // ***********************************************
  // wake frame detector
  // ***********************************************

  always_comb
  begin
    st_d      = st_q;
    idx_d     = idx_q;
    reps_d    = reps_q;
    dest_ok_d = dest_ok_q;
    found_d   = found_q;
    wake_hit  = 1'b0;
    if (rx_valid_i)
    begin
      if (rx_sof_i)
      begin
        // first byte is destination byte 0
        st_d      = EIC_ST_DEST;
        dest_ok_d = (rx_data_i == eic_addr_byte(station_address_i, 3'h0));
        idx_d     = 3'h1;
        reps_d    = 5'h00;
        found_d   = 1'b0;
      end
      else
      begin
        case (st_q)
          EIC_ST_DEST:
          begin
            dest_ok_d = dest_ok_q & (rx_data_i == eic_addr_byte(station_address_i, idx_q));
            if (idx_q == EIC_ADDR_LAST)
            begin
              idx_d = 3'h0;
              st_d  = EIC_ST_BODY;
            end
            else
            begin
              idx_d = idx_q + 3'h1;
            end
          end
          EIC_ST_BODY:
          begin
            // count whole address copies in a row
            if (!found_q)
            begin
              if (rx_data_i == eic_addr_byte(station_address_i, idx_q))
              begin
                if (idx_q == EIC_ADDR_LAST)
                begin
                  idx_d  = 3'h0;
                  reps_d = reps_q + 5'h01;
                  found_d = (reps_q == EIC_MAGIC_REPS - 5'h01);
                end
                else
                begin
                  idx_d = idx_q + 3'h1;
                end
              end
              else
              begin
                // broken run; this byte may open a new one
                reps_d = 5'h00;
                idx_d  = (rx_data_i == eic_addr_byte(station_address_i, 3'h0)) ? 3'h1 : 3'h0;
              end
            end
          end
          default:
          begin
            st_d = EIC_ST_IDLE;
          end
        endcase
      end
      // frame end decides
      if (rx_eof_i)
      begin
        st_d     = EIC_ST_IDLE;
        wake_hit = mode_q & found_d & (dest_ok_d | any_dest_eff);
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q      <= EIC_ST_IDLE;
      idx_q     <= 3'h0;
      reps_q    <= 5'h00;
      dest_ok_q <= 1'b0;
      found_q   <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      idx_q     <= idx_d;
      reps_q    <= reps_d;
      dest_ok_q <= dest_ok_d;
      found_q   <= found_d;
    end
  end

  // ***********************************************
  // interrupt outputs
  // ***********************************************

  // combined flag and pci interrupt, wake source needs the global enable only at the pci interrupt
  assign comb_int_d = (sys_flag_q & sys_ie_q) | (exd_flag_q & exd_ie_q) | (wake_flag_q & wake_ie_q);
  assign pci_int_d  = (sys_flag_q & sys_ie_q)
                    | (exd_flag_q & exd_ie_q)
                    | (wake_flag_q & wake_ie_q & gie_q);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      comb_int_q <= 1'b0;
      pci_int_q  <= 1'b0;
      mode_q     <= 1'b0;
    end
    else
    begin
      comb_int_q <= comb_int_d;
      pci_int_q  <= pci_int_d;
      mode_q     <= mode_d;
    end
  end

  assign prdata_o             = prdata_q;
  assign pready_o             = pready_q;
  assign pslverr_o            = pslverr_q;
  assign pci_int_o            = pci_int_q;
  assign combined_int_flag_o  = comb_int_q;
  assign wake_mode_o          = mode_q;
  assign last_tx_int_enable_o = ltx_ie_q;

endmodule

`default_nettype wire

// ---- eic_checker.sv ----
// checker of apb timing and interrupt output relations at the block ports
`timescale 1ns/1ps
`default_nettype none

module eic_checker
(
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       psel_i,
  input wire logic                       penable_i,
  input wire logic                       pwrite_i,
  input wire logic [eic_pkg::EIC_AW-1:0] paddr_i,
  input wire logic [31:0]                prdata_o,
  input wire logic                       pready_o,
  input wire logic                       pslverr_o,
  input wire logic                       bm_parity_err_i,
  input wire logic                       bm_master_abort_i,
  input wire logic                       bm_target_abort_i,
  input wire logic                       tx_excess_defer_i,
  input wire logic                       rx_valid_i,
  input wire logic                       rx_eof_i,
  input wire logic                       pci_int_o,
  input wire logic                       combined_int_flag_o,
  input wire logic                       wake_mode_o,
  input wire logic                       last_tx_int_enable_o
);
  import eic_pkg::*;

  // ***********************************************
  // helper terms
  // ***********************************************
  logic wr_done;
  logic evt_any;

  // completed write and flag setting events
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign evt_any = bm_parity_err_i || bm_master_abort_i || bm_target_abort_i || tx_excess_defer_i
                   || (rx_valid_i && rx_eof_i);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ***********************************************
  // assertions
  // ***********************************************
  AST_RST_QUIET:
  assert property (disable iff (1'b0) rst_i |=> !pci_int_o && !combined_int_flag_o && !wake_mode_o
                   && !last_tx_int_enable_o && !pready_o) else $error("outputs not quiet after reset");
  AST_SETUP_WAIT:
  assert property (psel_i && !penable_i |=> !pready_o) else $error("ready during first access cycle");
  AST_ACCESS_DONE:
  assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("ready not in second access cycle");
  AST_READY_PULSE:
  assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
  AST_ERR_MAP:
  assert property (pready_o |-> pslverr_o == (paddr_i != EIC_CTRL_OFS && paddr_i != EIC_AUX_OFS))
    else $error("error response does not match address map");
  AST_ERR_ZERO:
  assert property (pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
    else $error("refused read returns nonzero data");
  AST_PCI_SUBSET:
  assert property (pci_int_o |-> combined_int_flag_o) else $error("interrupt pin without combined flag");
  AST_INT_CAUSE:
  assert property ($rose(combined_int_flag_o) |-> $past(evt_any, 2) || $past(wr_done, 2))
    else $error("combined flag rose without cause");
  AST_INT_CLEAR:
  assert property ($fell(combined_int_flag_o) |-> $past(wr_done, 2) || $past(rst_i))
    else $error("combined flag fell without clear");
  AST_LTX_WRITE:
  assert property ($changed(last_tx_int_enable_o) |-> $past(wr_done) || $past(rst_i))
    else $error("last tx enable changed without write");

endmodule

`default_nettype wire

// ---- tb.sv ----
// self-checking testbench of the extended interrupt control bits block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import eic_pkg::*;

  // ***********************************************
  // constants and signals
  // ***********************************************
  localparam logic [31:0] B_LTX = 32'h0000_0001 << EIC_LTX_IE_BIT;
  localparam logic [31:0] B_SYF = 32'h0000_0001 << EIC_SYS_FLAG_BIT;
  localparam logic [31:0] B_SYE = 32'h0000_0001 << EIC_SYS_IE_BIT;
  localparam logic [31:0] B_EXF = 32'h0000_0001 << EIC_EXD_FLAG_BIT;
  localparam logic [31:0] B_EXE = 32'h0000_0001 << EIC_EXD_IE_BIT;
  localparam logic [31:0] B_ANY = 32'h0000_0001 << EIC_ANY_DEST_BIT;
  localparam logic [31:0] B_WKF = 32'h0000_0001 << EIC_WAKE_FLAG_BIT;
  localparam logic [31:0] B_WKE = 32'h0000_0001 << EIC_WAKE_IE_BIT;
  localparam logic [31:0] B_HWK = 32'h0000_0001 << EIC_HOST_WAKE_BIT;
  localparam logic [31:0] B_WMD = 32'h0000_0001 << EIC_WAKE_MODE_BIT;
  localparam logic [31:0] A_GIE = 32'h0000_0001 << EIC_GIE_BIT;
  localparam logic [31:0] A_EXT = 32'h0000_0001 << EIC_EXT_ANY_BIT;
  localparam logic [31:0] A_STP = 32'h0000_0001 << EIC_STOP_BIT;
  localparam logic [31:0] A_SRS = 32'h0000_0001 << EIC_SRST_BIT;
  localparam logic [31:0] A_MST = 32'h0000_0001 << EIC_MODE_ST_BIT;
  localparam logic [31:0] A_INT = 32'h0000_0001 << EIC_INT_ST_BIT;
  localparam logic [31:0] CFG   = B_LTX | B_SYE | B_EXE | B_ANY | B_WKE | B_HWK;
  localparam logic [31:0] WK    = B_WMD | B_HWK | B_WKE;
  localparam logic [47:0] STA   = 48'h0A1B_2C3D_4E5F;
  localparam logic [47:0] BC    = 48'hFFFF_FFFF_FFFF;

  logic        clk_i, rst_i, psel, penable, pwrite, rxv, rxs, rxe, pg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0]  rxd;
  logic [3:0]  evt;
  logic        pready, pslverr, pci, comb, wmode, ltx;
  int          mismatches, checks, k;

  eic_top dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .bm_parity_err_i(evt[0]), .bm_master_abort_i(evt[1]), .bm_target_abort_i(evt[2]),
    .tx_excess_defer_i(evt[3]), .rx_valid_i(rxv), .rx_sof_i(rxs), .rx_eof_i(rxe), .rx_data_i(rxd),
    .station_address_i(STA), .power_good_input_i(pg), .pci_int_o(pci), .combined_int_flag_o(comb),
    .wake_mode_o(wmode), .last_tx_int_enable_o(ltx)
  );

  // ***********************************************
  // tasks
  // ***********************************************
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // verdict and end of run
  task test_done;
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // one apb transfer, waits for ready under a bound
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    // look at ready between edges, where it is settled
    @(negedge clk_i);
    while (pready !== 1'b1 && n < 16)
    begin
      @(negedge clk_i);
      n++;
    end
    if (pready !== 1'b1)
    begin
      mismatches++;
      test_done();
    end
    q = prdata;
    e = pslverr;
    // transfer completes at this rising edge, then release
    @(posedge clk_i);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task wrc(input logic [11:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] x, input logic ee);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, x);
    chk({31'h0, e}, {31'h0, ee});
  endtask

  // output levels: pci, combined, wake mode, last tx enable
  task sts(input logic [3:0] x);
    @(negedge clk_i); // outputs settled, away from the launching edge
    chk({28'h0, pci, comb, wmode, ltx}, {28'h0, x});
  endtask

  // one cycle event pulse, then time for the interrupt to follow
  task pulse(input int n);
    @(posedge clk_i);
    evt <= 4'h1 << n;
    @(posedge clk_i);
    evt <= 4'h0;
    repeat (2) @(posedge clk_i);
  endtask

  // frame: destination then address copies, first byte of address sent first
  task frame(input logic [47:0] dst, input int reps);
    int i;
    int n;
    n = 6 + 6 * reps;
    for (i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      rxv <= 1'b1;
      rxs <= (i == 0);
      rxe <= (i == n - 1);
      rxd <= (i < 6) ? dst[47 - 8 * i -: 8] : STA[47 - 8 * (i % 6) -: 8];
    end
    @(posedge clk_i);
    rxv <= 1'b0;
    rxs <= 1'b0;
    rxe <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // ***********************************************
  // clock, watchdog and sequence
  // ***********************************************
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (50000) @(posedge clk_i);
    mismatches++;
    test_done();
  end

  initial
  begin
    {psel, penable, pwrite, rxv, rxs, rxe, pg} = 7'h00;
    {paddr, pwdata, rxd, evt} = 56'h0;
    mismatches = 0;
    checks = 0;
    rst_i = 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    sts(4'h0);
    rdc(EIC_CTRL_OFS, 32'h0, 1'b0);
    rdc(EIC_AUX_OFS, 32'h0, 1'b0);
    wrc(EIC_CTRL_OFS, CFG, 1'b0);
    wrc(12'h008, 32'hFFFF_FFFF, 1'b1);
    rdc(12'h008, 32'h0, 1'b1);
    rdc(EIC_CTRL_OFS, CFG, 1'b0);
    sts(4'h1);
    for (k = 0; k < 3; k++)
    begin
      pulse(k);
      sts(4'hD);
      wrc(EIC_CTRL_OFS, CFG, 1'b0);
      rdc(EIC_CTRL_OFS, CFG | B_SYF, 1'b0);
      wrc(EIC_CTRL_OFS, CFG | B_SYF, 1'b0);
      rdc(EIC_CTRL_OFS, CFG, 1'b0);
      sts(4'h1);
    end
    wrc(EIC_CTRL_OFS, CFG & ~B_SYE, 1'b0);
    pulse(0);
    sts(4'h1);
    wrc(EIC_CTRL_OFS, CFG | B_SYF, 1'b0);
    pulse(3);
    sts(4'hD);
    fork
      begin
        repeat (3) @(posedge clk_i);
        evt <= 4'h1;
        @(posedge clk_i);
        evt <= 4'h0;
      end
      wrc(EIC_CTRL_OFS, CFG | B_EXF | B_SYF, 1'b0);
    join
    rdc(EIC_CTRL_OFS, CFG | B_SYF, 1'b0);
    pulse(3);
    wrc(EIC_AUX_OFS, A_SRS, 1'b0);
    rdc(EIC_CTRL_OFS, B_EXF | B_EXE, 1'b0);
    sts(4'hC);
    wrc(EIC_CTRL_OFS, CFG | B_EXF, 1'b0);
    pulse(1);
    wrc(EIC_AUX_OFS, A_GIE, 1'b0);
    wrc(EIC_AUX_OFS, A_STP, 1'b0);
    rdc(EIC_CTRL_OFS, CFG | B_SYF, 1'b0);
    rdc(EIC_AUX_OFS, A_INT, 1'b0);
    sts(4'hD);
    pulse(3);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(EIC_CTRL_OFS, 32'h0, 1'b0);
    wrc(EIC_CTRL_OFS, WK, 1'b0);
    rdc(EIC_AUX_OFS, A_MST, 1'b0);
    frame(STA, 16);
    sts(4'h6);
    wrc(EIC_AUX_OFS, A_GIE, 1'b0);
    repeat (2) @(posedge clk_i);
    sts(4'hE);
    rdc(EIC_CTRL_OFS, WK | B_WKF, 1'b0);
    wrc(EIC_CTRL_OFS, WK | B_WKF, 1'b0);
    rdc(EIC_CTRL_OFS, WK, 1'b0);
    frame(STA, 15);
    rdc(EIC_CTRL_OFS, WK, 1'b0);
    frame(BC, 16);
    rdc(EIC_CTRL_OFS, WK, 1'b0);
    wrc(EIC_AUX_OFS, A_GIE | A_EXT, 1'b0);
    frame(BC, 16);
    rdc(EIC_CTRL_OFS, WK | B_WKF, 1'b0);
    wrc(EIC_AUX_OFS, A_GIE, 1'b0);
    wrc(EIC_CTRL_OFS, WK | B_ANY | B_WKF, 1'b0);
    frame(BC, 16);
    rdc(EIC_CTRL_OFS, WK | B_ANY | B_WKF, 1'b0);
    wrc(EIC_AUX_OFS, A_STP, 1'b0);
    rdc(EIC_CTRL_OFS, WK | B_ANY, 1'b0);
    wrc(EIC_CTRL_OFS, B_WMD, 1'b0);
    pg <= 1'b1;
    repeat (8) @(posedge clk_i);
    sts(4'h2);
    frame(STA, 16);
    rdc(EIC_CTRL_OFS, B_WMD | B_WKF, 1'b0);
    pg <= 1'b0;
    repeat (8) @(posedge clk_i);
    sts(4'h0);
    wrc(EIC_CTRL_OFS, B_WMD | B_WKF, 1'b0);
    frame(STA, 16);
    rdc(EIC_CTRL_OFS, B_WMD, 1'b0);
    test_done();
  end

endmodule

bind eic_top eic_checker u_chk
(
  .clk_i, .rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o,
  .bm_parity_err_i, .bm_master_abort_i, .bm_target_abort_i, .tx_excess_defer_i, .rx_valid_i,
  .rx_eof_i, .pci_int_o, .combined_int_flag_o, .wake_mode_o, .last_tx_int_enable_o
);

`default_nettype wire
